/* src/lsc_pkg.sv */
// ***************************************************************
// Shared constants for the scanner and laser control block.
// ***************************************************************
package lsc_pkg;
	localparam int unsigned CLOCK_HZ = 20000000;
	localparam int unsigned MS_PER_S = 1000;
	localparam int unsigned CYC_PER_MS = CLOCK_HZ / MS_PER_S;
	localparam int unsigned SPINUP_TIMEOUT_MS = 20000;
	localparam int unsigned STALL_TIMEOUT_MS = 2500;
	localparam int unsigned SPINUP_TIMEOUT_CYC = SPINUP_TIMEOUT_MS * CYC_PER_MS;
	localparam int unsigned STALL_TIMEOUT_CYC = STALL_TIMEOUT_MS * CYC_PER_MS;
	localparam int unsigned SCAN_REF_HALF_CYC = 1000;
	localparam int unsigned RAMP_STEP_CYC = 200;
	localparam int unsigned LOOP_STEP_CYC = 100;
	localparam int unsigned PIXEL_DIV_CYC = 2;
	localparam int unsigned FIFO_DEPTH = 8;
	localparam int unsigned POWER_WIDTH = 8;
	localparam logic [7:0] POWER_SETPOINT = 8'h80;
	localparam logic [7:0] POWER_RESET = 8'h00;
	localparam int unsigned PIN_PRINT = 0;
	localparam int unsigned PIN_FRAME = 1;
	localparam int unsigned PIN_SPEED = 2;
	localparam int unsigned PIN_BEAM = 3;
	localparam int unsigned PIN_VIDEO = 4;
	localparam int unsigned PIN_COUNT = 5;
	localparam logic [4:0] PIN_IDLE = 5'h1f;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ARMED,
		ST_SPINUP,
		ST_RUN,
		ST_ERROR
	} lsc_state_t;
endpackage

/* src/lsc_fifo.sv */
`timescale 1ns/100ps
// ***************************************************************
// Small synchronous FIFO with valid and ready on both sides.
// ***************************************************************
module lsc_fifo #(
	parameter int unsigned WIDTH = 1,
	parameter int unsigned DEPTH = 8
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic sys_rst,
	// Fill side.
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side.
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int unsigned CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wptr;
		logic [PW-1:0] rptr;
		logic [CW-1:0] count;
	} lsc_fifo_state_t;

	lsc_fifo_state_t q;
	lsc_fifo_state_t d;
	logic push;
	logic pop;

	assign in_ready = (q.count != CW'(DEPTH));
	assign out_valid = (q.count != '0);
	assign out_data = q.mem[q.rptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		d = q;
		if (push) begin
			d.mem[q.wptr] = in_data;
			d.wptr = (q.wptr == PW'(DEPTH - 1)) ? '0 : PW'(q.wptr + 1'b1);
		end
		if (pop) begin
			d.rptr = (q.rptr == PW'(DEPTH - 1)) ? '0 : PW'(q.rptr + 1'b1);
		end
		if (push && !pop) begin
			d.count = CW'(q.count + 1'b1);
		end else if (pop && !push) begin
			d.count = CW'(q.count - 1'b1);
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule

/* src/lsc_top.sv */
`timescale 1ns/100ps
// Functional notes
// - Scanner speed reference clock toggles continuously from reset onward.
// - Motor stays stopped after reset until frame sync arrives while a print request is held.
// - Frame sync asserts motor run, laser enable and laser force-on, all low.
// - At-speed not low within 20 s of run request gives motor error.
// - At-speed high for more than 2.5 s while running gives motor error.
// - Beam detect pulse is forwarded to the video side as line sync.
// - Serial video data is relayed to the laser driver as laser data.
// - Force-on asserts first, then power level rises in small steps.
// - With laser on, power level tracks photodiode feedback in a closed loop.
// ***************************************************************
// Scanner motor and laser control.
// ***************************************************************
module lsc_top #(
	parameter int unsigned SPINUP_LIMIT_CYC = lsc_pkg::SPINUP_TIMEOUT_CYC,
	parameter int unsigned STALL_LIMIT_CYC = lsc_pkg::STALL_TIMEOUT_CYC,
	parameter int unsigned REF_HALF_CYC = lsc_pkg::SCAN_REF_HALF_CYC,
	parameter int unsigned FIFO_DEPTH = lsc_pkg::FIFO_DEPTH,
	parameter logic [7:0] POWER_SETPOINT = lsc_pkg::POWER_SETPOINT
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic sys_rst,
	// Video controller side.
	input wire logic print_request_n,
	input wire logic frame_sync_in_n,
	input wire logic video_serial_in_n,
	output logic line_sync_out_n,
	output logic video_ready,
	// Scanner motor driver.
	output logic scanner_speed_ref_clock,
	output logic motor_run_request_n,
	input wire logic motor_at_speed_n,
	output logic motor_error,
	// Beam detector and laser driver.
	input wire logic beam_detect_in_n,
	output logic laser_enable_n,
	output logic laser_force_on_n,
	output logic laser_data_out_n,
	output logic [7:0] laser_power_level_out,
	input wire logic [7:0] photodiode_feedback_in
);
	localparam int unsigned NP = lsc_pkg::PIN_COUNT;
	localparam logic [7:0] PWR_MAX = 8'hff;

	typedef struct packed {
		logic [NP-1:0] sy1;
		logic [NP-1:0] sy2;
		logic [NP-1:0] sy3;
		logic [NP-1:0] pin;
		lsc_pkg::lsc_state_t state;
		logic [31:0] timer;
		logic [15:0] ref_cnt;
		logic ref_clk;
		logic [15:0] ramp_cnt;
		logic [15:0] loop_cnt;
		logic [15:0] pix_cnt;
		logic ramping;
		logic [7:0] level;
		logic line_sync_n;
		logic data_n;
	} lsc_top_state_t;

	lsc_top_state_t q;
	lsc_top_state_t d;
	logic ramp_en;
	logic loop_en;
	logic pix_en;
	logic active;
	logic fifo_in_valid;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic fifo_out_data;
	logic pop;

	assign ramp_en = (q.ramp_cnt == 16'(lsc_pkg::RAMP_STEP_CYC - 1));
	assign loop_en = (q.loop_cnt == 16'(lsc_pkg::LOOP_STEP_CYC - 1));
	assign pix_en = (q.pix_cnt == 16'(lsc_pkg::PIXEL_DIV_CYC - 1));
	assign active = (q.state == lsc_pkg::ST_SPINUP) || (q.state == lsc_pkg::ST_RUN);
	assign fifo_in_valid = (q.state == lsc_pkg::ST_RUN) && pix_en;
	assign fifo_out_ready = (q.state == lsc_pkg::ST_RUN) && !q.ramping && pix_en;
	assign pop = fifo_out_valid && fifo_out_ready;

	// ***************************************************************
	// Video data buffer between the video side and the laser driver.
	// ***************************************************************
	lsc_fifo #(
		.WIDTH(1),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.sys_rst(sys_rst),
		.in_valid(fifo_in_valid),
		.in_ready(video_ready),
		.in_data(q.pin[lsc_pkg::PIN_VIDEO]),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	// ***************************************************************
	// Next-state logic.
	// ***************************************************************
	always_comb begin
		d = q;
		// Pins pass three flops; a level counts once the last two agree.
		d.sy1 = {video_serial_in_n, beam_detect_in_n, motor_at_speed_n,
			frame_sync_in_n, print_request_n};
		d.sy2 = q.sy1;
		d.sy3 = q.sy2;
		d.pin = ((q.sy2 ~^ q.sy3) & q.sy3) | ((q.sy2 ^ q.sy3) & q.pin);
		d.ramp_cnt = ramp_en ? '0 : 16'(q.ramp_cnt + 1'b1);
		d.loop_cnt = loop_en ? '0 : 16'(q.loop_cnt + 1'b1);
		d.pix_cnt = pix_en ? '0 : 16'(q.pix_cnt + 1'b1);
		if (q.ref_cnt == 16'(REF_HALF_CYC - 1)) begin
			d.ref_cnt = '0;
			d.ref_clk = !q.ref_clk;
		end else begin
			d.ref_cnt = 16'(q.ref_cnt + 1'b1);
		end
		d.line_sync_n = q.pin[lsc_pkg::PIN_BEAM];
		case (q.state)
			lsc_pkg::ST_IDLE: begin
				if (!q.pin[lsc_pkg::PIN_PRINT]) begin
					d.state = lsc_pkg::ST_ARMED;
				end
			end
			lsc_pkg::ST_ARMED: begin
				if (q.pin[lsc_pkg::PIN_PRINT]) begin
					d.state = lsc_pkg::ST_IDLE;
				end else if (!q.pin[lsc_pkg::PIN_FRAME]) begin
					d.state = lsc_pkg::ST_SPINUP;
					d.timer = '0;
					// Restart the step divider so the first power step comes a full step later.
					d.ramp_cnt = '0;
				end
			end
			lsc_pkg::ST_SPINUP: begin
				if (!q.pin[lsc_pkg::PIN_SPEED]) begin
					d.state = lsc_pkg::ST_RUN;
					d.timer = '0;
				end else if (q.timer >= 32'(SPINUP_LIMIT_CYC - 1)) begin
					d.state = lsc_pkg::ST_ERROR;
				end else begin
					d.timer = 32'(q.timer + 1'b1);
				end
			end
			lsc_pkg::ST_RUN: begin
				if (q.pin[lsc_pkg::PIN_PRINT]) begin
					d.state = lsc_pkg::ST_IDLE;
				end else if (!q.pin[lsc_pkg::PIN_SPEED]) begin
					d.timer = '0;
				end else if (q.timer >= 32'(STALL_LIMIT_CYC)) begin
					d.state = lsc_pkg::ST_ERROR;
				end else begin
					d.timer = 32'(q.timer + 1'b1);
				end
			end
			lsc_pkg::ST_ERROR: begin
				d.state = lsc_pkg::ST_ERROR;
			end
			default: begin
				d.state = lsc_pkg::ST_ERROR;
			end
		endcase
		// Power starts at zero with force-on asserted, then climbs until feedback is met or the level reaches 8'hff.
		if (!active) begin
			d.level = lsc_pkg::POWER_RESET;
			d.ramping = (d.state == lsc_pkg::ST_SPINUP);
		end else if (q.ramping) begin
			if (ramp_en) begin
				if (photodiode_feedback_in >= POWER_SETPOINT || q.level == PWR_MAX) begin
					d.ramping = 1'b0;
				end else begin
					d.level = 8'(q.level + 1'b1);
				end
			end
		end else if (loop_en) begin
			if (photodiode_feedback_in < POWER_SETPOINT && q.level != PWR_MAX) begin
				d.level = 8'(q.level + 1'b1);
			end else if (photodiode_feedback_in > POWER_SETPOINT && q.level != 8'h00) begin
				d.level = 8'(q.level - 1'b1);
			end
		end
		if (q.state != lsc_pkg::ST_RUN) begin
			d.data_n = 1'b1;
		end else if (pop) begin
			d.data_n = fifo_out_data;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			q <= '0;
			q.sy1 <= lsc_pkg::PIN_IDLE;
			q.sy2 <= lsc_pkg::PIN_IDLE;
			q.sy3 <= lsc_pkg::PIN_IDLE;
			q.pin <= lsc_pkg::PIN_IDLE;
			q.state <= lsc_pkg::ST_IDLE;
			q.line_sync_n <= 1'b1;
			q.data_n <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// ***************************************************************
	// Outputs.
	// ***************************************************************
	assign scanner_speed_ref_clock = q.ref_clk;
	assign motor_run_request_n = !active;
	assign laser_enable_n = !active;
	assign laser_force_on_n = !active;
	assign motor_error = (q.state == lsc_pkg::ST_ERROR);
	assign line_sync_out_n = q.line_sync_n;
	assign laser_data_out_n = q.data_n;
	assign laser_power_level_out = q.level;

	// ***************************************************************
	// Checks.
	// ***************************************************************
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	logic [15:0] ref_hold;
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			ref_hold <= '0;
		end else if (d.ref_clk != q.ref_clk) begin
			ref_hold <= '0;
		end else begin
			ref_hold <= 16'(ref_hold + 1'b1);
		end
	end

	sequence frame_seen_s;
		q.state == lsc_pkg::ST_ARMED && !q.pin[lsc_pkg::PIN_PRINT] && !q.pin[lsc_pkg::PIN_FRAME];
	endsequence
	sequence all_on_s;
		!motor_run_request_n && !laser_enable_n && !laser_force_on_n;
	endsequence

	ref_toggle_a: assert property (ref_hold < 16'(REF_HALF_CYC))
		else $error("speed reference clock stopped");
	motor_idle_a: assert property (q.state == lsc_pkg::ST_IDLE |-> motor_run_request_n)
		else $error("motor runs without print request");
	frame_start_a: assert property (frame_seen_s |=> all_on_s ##1 all_on_s or motor_error)
		else $error("frame sync did not start motor and laser");
	spinup_limit_a: assert property (q.state == lsc_pkg::ST_SPINUP && q.pin[lsc_pkg::PIN_SPEED]
		&& q.timer == 32'(SPINUP_LIMIT_CYC - 1) |=> motor_error)
		else $error("spin-up timeout missed");
	stall_limit_a: assert property (q.state == lsc_pkg::ST_RUN && !q.pin[lsc_pkg::PIN_PRINT]
		&& q.pin[lsc_pkg::PIN_SPEED] && q.timer < 32'(STALL_LIMIT_CYC) |=> !motor_error)
		else $error("stall error raised early");
	line_sync_a: assert property (##1 line_sync_out_n == $past(q.pin[lsc_pkg::PIN_BEAM]))
		else $error("line sync does not follow beam detect");
	laser_data_a: assert property (pop |=> laser_data_out_n == $past(fifo_out_data))
		else $error("laser data not relayed");
	ramp_order_a: assert property ($fell(laser_force_on_n) |-> laser_power_level_out == 8'h00
		##1 laser_power_level_out == 8'h00)
		else $error("power rose before force-on");
	loop_up_a: assert property (active && !q.ramping && loop_en && q.level != PWR_MAX
		&& photodiode_feedback_in < POWER_SETPOINT |=> $past(q.level) + 8'h01 == laser_power_level_out
		|| !active)
		else $error("power loop did not raise level");
	error_safe_a: assert property (motor_error |-> motor_run_request_n && laser_enable_n
		&& laser_force_on_n ##1 motor_error)
		else $error("outputs active during motor error");
	timer_clear_a: assert property (q.state == lsc_pkg::ST_RUN && !q.pin[lsc_pkg::PIN_PRINT]
		&& !q.pin[lsc_pkg::PIN_SPEED] |=> q.timer == 32'h0000_0000)
		else $error("stall timer not cleared");
endmodule

/* bench/lsc_far_model.sv */
`timescale 1ns/100ps
// ***************************************************************
// Motor driver, beam detector, photodiode and video source.
// ***************************************************************
module lsc_far_model (
	// Clock and reset.
	input wire logic clock,
	input wire logic sys_rst,
	// Scenario controls.
	input wire logic spin_ok,
	input wire logic stall,
	input wire logic [7:0] fb_bias,
	// Block outputs seen here.
	input wire logic motor_run_request_n,
	input wire logic line_sync_out_n,
	input wire logic [7:0] laser_power_level_out,
	// Block inputs made here.
	output logic motor_at_speed_n,
	output logic beam_detect_in_n,
	output logic video_serial_in_n,
	output logic [7:0] photodiode_feedback_in
);
	logic [9:0] run_cnt;
	logic [9:0] beam_cnt;
	logic [9:0] vid_cnt;
	logic ls_q;
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			run_cnt <= 10'h0;
			beam_cnt <= 10'h0;
			vid_cnt <= 10'h0;
			ls_q <= 1'b1;
		end else begin
			run_cnt <= motor_run_request_n ? 10'h0 : run_cnt + {9'h0, run_cnt != 10'h3ff};
			beam_cnt <= (beam_cnt == 10'h12b) ? 10'h0 : beam_cnt + 10'h1;
			ls_q <= line_sync_out_n;
			if (ls_q && !line_sync_out_n) begin
				vid_cnt <= 10'h28;
			end else if (vid_cnt != 10'h0) begin
				vid_cnt <= vid_cnt - 10'h1;
			end
		end
	end
	assign motor_at_speed_n = !(spin_ok && !stall && run_cnt >= 10'h1e);
	assign beam_detect_in_n = !(!motor_at_speed_n && beam_cnt < 10'h4);
	assign video_serial_in_n = (vid_cnt == 10'h0);
	assign photodiode_feedback_in = {laser_power_level_out[3:0], 4'h0} + fb_bias;
endmodule

/* bench/tb.sv */
`timescale 1ns/100ps
module tb;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic print_request_n = 1'b1;
	logic frame_sync_in_n = 1'b1;
	logic spin_ok = 1'b1;
	logic stall = 1'b0;
	logic [7:0] fb_bias = 8'h00;
	logic video_serial_in_n, line_sync_out_n, video_ready, scanner_speed_ref_clock;
	logic motor_run_request_n, motor_at_speed_n, motor_error, beam_detect_in_n;
	logic laser_enable_n, laser_force_on_n, laser_data_out_n;
	logic [7:0] laser_power_level_out;
	logic [7:0] photodiode_feedback_in;
	int errors = 0;
	int compares = 0;
	int cycles = 0;
	initial forever #25 clock = ~clock;
	lsc_top #(.SPINUP_LIMIT_CYC(200), .STALL_LIMIT_CYC(100), .REF_HALF_CYC(10)) dut_u (
		.clock(clock), .sys_rst(sys_rst), .print_request_n(print_request_n),
		.frame_sync_in_n(frame_sync_in_n), .video_serial_in_n(video_serial_in_n),
		.line_sync_out_n(line_sync_out_n), .video_ready(video_ready),
		.scanner_speed_ref_clock(scanner_speed_ref_clock),
		.motor_run_request_n(motor_run_request_n), .motor_at_speed_n(motor_at_speed_n),
		.motor_error(motor_error), .beam_detect_in_n(beam_detect_in_n),
		.laser_enable_n(laser_enable_n), .laser_force_on_n(laser_force_on_n),
		.laser_data_out_n(laser_data_out_n), .laser_power_level_out(laser_power_level_out),
		.photodiode_feedback_in(photodiode_feedback_in));
	lsc_far_model far_u (
		.clock(clock), .sys_rst(sys_rst), .spin_ok(spin_ok), .stall(stall), .fb_bias(fb_bias),
		.motor_run_request_n(motor_run_request_n), .line_sync_out_n(line_sync_out_n),
		.laser_power_level_out(laser_power_level_out), .motor_at_speed_n(motor_at_speed_n),
		.beam_detect_in_n(beam_detect_in_n), .video_serial_in_n(video_serial_in_n),
		.photodiode_feedback_in(photodiode_feedback_in));
	// ***************************************************************
	// Shared helpers.
	// ***************************************************************
	task summarize;
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			summarize();
		end
	end
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(negedge clock);
	endtask
	task do_reset;
		sys_rst = 1'b1;
		print_request_n = 1'b1;
		frame_sync_in_n = 1'b1;
		cyc(8);
		sys_rst = 1'b0;
		cyc(2);
	endtask
	task start_frame;
		print_request_n = 1'b0;
		cyc(30);
		chk("run_before_frame", motor_run_request_n, 1);
		frame_sync_in_n = 1'b0;
		cyc(12);
	endtask
	// ***************************************************************
	// Scenarios.
	// ***************************************************************
	task t_idle;
		int n;
		logic s;
		chk("run_after_reset", motor_run_request_n, 1);
		s = scanner_speed_ref_clock;
		n = 0;
		while (scanner_speed_ref_clock === s && n < 50) begin cyc(1); n++; end
		s = scanner_speed_ref_clock;
		n = 0;
		while (scanner_speed_ref_clock === s && n < 50) begin cyc(1); n++; end
		chk("ref_half_period", n, 10);
	endtask
	task t_ramp;
		int n;
		logic [7:0] prev;
		logic step_ok;
		logic full_seen;
		start_frame();
		chk("run_n", motor_run_request_n, 0);
		chk("enable_n", laser_enable_n, 0);
		chk("force_on_n", laser_force_on_n, 0);
		chk("level_start", laser_power_level_out, 0);
		n = 0;
		step_ok = 1'b1;
		full_seen = 1'b0;
		prev = laser_power_level_out;
		while (laser_power_level_out !== 8'h08 && n < 2500) begin
			cyc(1);
			n++;
			if (laser_power_level_out !== prev && laser_power_level_out !== prev + 8'h01)
				step_ok = 1'b0;
			if (video_ready === 1'b0)
				full_seen = 1'b1;
			prev = laser_power_level_out;
		end
		chk("ramp_steps", step_ok, 1);
		chk("ramp_time", n >= 1400 && n <= 1800, 1);
		chk("fifo_full_in_ramp", full_seen, 1);
		cyc(600);
		chk("level_hold", laser_power_level_out, 8'h08);
		chk("fifo_drains", video_ready, 1);
		chk("no_spinup_error", motor_error, 0);
		fb_bias = 8'h20;
		cyc(800);
		chk("level_track", laser_power_level_out, 8'h06);
		fb_bias = 8'h00;
	endtask
	task t_line;
		int n;
		n = 0;
		while (beam_detect_in_n !== 1'b1 && n < 20) begin cyc(1); n++; end
		n = 0;
		while (beam_detect_in_n !== 1'b0 && n < 400) begin cyc(1); n++; end
		n = 0;
		while (line_sync_out_n !== 1'b0 && n < 20) begin cyc(1); n++; end
		chk("line_sync_delay", n, 5);
		n = 0;
		while (laser_data_out_n !== 1'b0 && n < 80) begin cyc(1); n++; end
		chk("laser_data_low", laser_data_out_n, 0);
		n = 0;
		while (laser_data_out_n !== 1'b1 && n < 100) begin cyc(1); n++; end
		chk("laser_data_high", laser_data_out_n, 1);
	endtask
	task t_stall;
		int n;
		stall = 1'b1;
		cyc(50);
		stall = 1'b0;
		cyc(20);
		chk("short_drop", motor_error, 0);
		stall = 1'b1;
		n = 0;
		while (motor_error !== 1'b1 && n < 200) begin cyc(1); n++; end
		chk("stall_time", n >= 100 && n <= 112, 1);
		chk("stall_run_off", motor_run_request_n, 1);
		chk("stall_enable_off", laser_enable_n, 1);
		chk("stall_force_off", laser_force_on_n, 1);
		stall = 1'b0;
		cyc(50);
		chk("error_held", motor_error, 1);
	endtask
	task t_spinup;
		int n;
		do_reset();
		spin_ok = 1'b0;
		print_request_n = 1'b0;
		cyc(30);
		frame_sync_in_n = 1'b0;
		n = 0;
		while (motor_run_request_n !== 1'b0 && n < 20) begin cyc(1); n++; end
		n = 0;
		while (motor_error !== 1'b1 && n < 400) begin cyc(1); n++; end
		chk("spinup_time", n >= 195 && n <= 205, 1);
		chk("spinup_run_off", motor_run_request_n, 1);
		do_reset();
		chk("error_cleared", motor_error, 0);
	endtask
	task t_release;
		spin_ok = 1'b1;
		print_request_n = 1'b0;
		cyc(30);
		print_request_n = 1'b1;
		cyc(10);
		frame_sync_in_n = 1'b0;
		cyc(12);
		chk("frame_without_print", motor_run_request_n, 1);
		print_request_n = 1'b0;
		cyc(60);
		chk("run_with_print", motor_run_request_n, 0);
		print_request_n = 1'b1;
		cyc(8);
		chk("run_after_release", motor_run_request_n, 1);
		chk("no_error_on_release", motor_error, 0);
	endtask
	initial begin
		do_reset();
		t_idle();
		t_ramp();
		t_line();
		t_stall();
		t_spinup();
		t_release();
		summarize();
	end
endmodule
